/* hdl/cmpreg_top.sv */
// Control, mode and edge-flag register bank of the second analog comparator.
//
// Behaviour
// - Comparator runs only while on bit set.
// - Bit 6 reads the live compare result.
// - Rising edge sets sticky flag, software clears.
// - Falling edge sets sticky flag, software clears.
// - Bits 3:2 drive upper hysteresis level.
// - Bits 1:0 drive lower hysteresis level.
// - Control register at 0x9A, resets zero.
// - Mode register at 0x9C, resets 0x82.
// - Mode bit 7 always reads one.
// - Mode bit 6 reads zero, writes ignored.
// - Mode bits 3:2 read zero, ignored.
// - Rising flag interrupts only when enabled.
// - Falling flag interrupts only when enabled.
// - Mode bits 1:0 set response speed.
// - Compare result feeds timer capture inputs.
// - Half-supply divider on only when selected.
// - Hysteresis codes mean 0/5/10/20 mV.
`timescale 1ns/1ps
module cmpreg_top #(
    parameter int SYNC_STAGES = 2                 // Depth of the result synchroniser.
) (
    // Clock and reset.
    input  wire logic                         ref_clk,
    input  wire logic                         rst_n,
    // Register bus from the core.
    input  wire cmpreg_pkg::cmpreg_sfr_req_t  sfr_req,
    output logic [cmpreg_pkg::DATA_W-1:0]     sfr_rdata_q,
    // Analog comparator core.
    input  wire logic                         cmp_raw,
    input  wire logic [3:0]                   pos_sel,
    input  wire logic [3:0]                   neg_sel,
    output cmpreg_pkg::cmpreg_ana_ctl_t       ana_ctl_q,
    output logic                              half_div_en_q,
    // Timer capture and interrupt.
    output logic                              cap_second_timer_q,
    output logic                              cap_third_timer_q,
    output logic                              irq_q
);
    import cmpreg_pkg::*;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    logic hit_ctl;                                // Access aims at the control register.
    logic hit_mode;                               // Access aims at the mode register.
    logic wr_ctl;                                 // Write to the control register.
    logic wr_mode;                                // Write to the mode register.

    // Both registers live on page zero only.
    always_comb begin
        hit_ctl  = (sfr_req.page == PAGE_CMP) && (sfr_req.addr == ADDR_CTL);
        hit_mode = (sfr_req.page == PAGE_CMP) && (sfr_req.addr == ADDR_MODE);
        wr_ctl   = sfr_req.wr && hit_ctl;
        wr_mode  = sfr_req.wr && hit_mode;
    end

    // ------------------------------------------------------------
    // Control register storage
    // ------------------------------------------------------------
    logic       on_q;                             // Comparator on bit.
    logic [1:0] hyp_q;                            // Upper hysteresis level code.
    logic [1:0] hyn_q;                            // Lower hysteresis level code.

    // Software writes the on bit and both hysteresis fields; bit 6 is ignored.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            on_q  <= CTL_RESET[CTL_ON];
            hyp_q <= CTL_RESET[CTL_HYP_LO +: 2];
            hyn_q <= CTL_RESET[CTL_HYN_LO +: 2];
        end else if (wr_ctl) begin
            on_q  <= sfr_req.wdata[CTL_ON];
            hyp_q <= sfr_req.wdata[CTL_HYP_LO +: 2];
            hyn_q <= sfr_req.wdata[CTL_HYN_LO +: 2];
        end
    end

    // ------------------------------------------------------------
    // Mode register storage
    // ------------------------------------------------------------
    logic       rie_q;                            // Rising-edge interrupt enable.
    logic       fie_q;                            // Falling-edge interrupt enable.
    logic [1:0] spd_q;                            // Response speed code.

    // Bits 7, 6 and 3:2 hold no state, so writes to them vanish.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rie_q <= MODE_RESET[MODE_RIE];
            fie_q <= MODE_RESET[MODE_FIE];
            spd_q <= SPD_RESET;
        end else if (wr_mode) begin
            rie_q <= sfr_req.wdata[MODE_RIE];
            fie_q <= sfr_req.wdata[MODE_FIE];
            spd_q <= sfr_req.wdata[MODE_SPD_LO +: 2];
        end
    end

    // ------------------------------------------------------------
    // Compare result path
    // ------------------------------------------------------------
    logic raw_sync;                               // Synchronised comparator output.
    logic res_q;                                  // Result as seen by software.
    logic res_prev_q;                             // Result one cycle earlier.
    logic rise_evt;                               // Result went from zero to one.
    logic fall_evt;                               // Result went from one to zero.

    // The analog output is asynchronous, so it crosses a flip-flop chain first.
    cmpreg_sync #(
        .STAGES   (SYNC_STAGES)
    ) u_sync (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .async_in (cmp_raw),
        .sync_out (raw_sync)
    );

    // A disabled comparator reads zero, since its core output is meaningless.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            res_q      <= 1'b0;
            res_prev_q <= 1'b0;
        end else begin
            res_q      <= raw_sync && on_q;
            res_prev_q <= res_q;
        end
    end

    // Edges are taken between the two clean copies of the result.
    always_comb begin
        rise_evt = res_q && !res_prev_q;
        fall_evt = !res_q && res_prev_q;
    end

    // ------------------------------------------------------------
    // Sticky edge flags
    // ------------------------------------------------------------
    logic rise_flag;                              // Rising-edge flag.
    logic fall_flag;                              // Falling-edge flag.

    // Rising-edge flag; an edge in a clearing cycle still sets it.
    cmpreg_flag u_rise (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .set_evt  (rise_evt),
        .wr_en    (wr_ctl),
        .wr_bit   (sfr_req.wdata[CTL_RISE]),
        .flag_q   (rise_flag)
    );

    // Falling-edge flag; same behaviour as the rising one.
    cmpreg_flag u_fall (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .set_evt  (fall_evt),
        .wr_en    (wr_ctl),
        .wr_bit   (sfr_req.wdata[CTL_FALL]),
        .flag_q   (fall_flag)
    );

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    logic [DATA_W-1:0] ctl_view;                  // Control register as read.
    logic [DATA_W-1:0] mode_view;                 // Mode register as read.

    // Assemble both registers; unused mode bits read zero, bit 7 reads one.
    always_comb begin
        ctl_view                     = '0;
        ctl_view[CTL_ON]             = on_q;
        ctl_view[CTL_RES]            = res_q;
        ctl_view[CTL_RISE]           = rise_flag;
        ctl_view[CTL_FALL]           = fall_flag;
        ctl_view[CTL_HYP_LO +: 2]    = hyp_q;
        ctl_view[CTL_HYN_LO +: 2]    = hyn_q;
        mode_view                    = '0;
        mode_view[MODE_RSV]          = 1'b1;
        mode_view[MODE_RIE]          = rie_q;
        mode_view[MODE_FIE]          = fie_q;
        mode_view[MODE_SPD_LO +: 2]  = spd_q;
    end

    // Read data appear one cycle after the strobe; other addresses return zero.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sfr_rdata_q <= '0;
        end else if (sfr_req.rd) begin
            if (hit_ctl) begin
                sfr_rdata_q <= ctl_view;
            end else if (hit_mode) begin
                sfr_rdata_q <= mode_view;
            end else begin
                sfr_rdata_q <= '0;
            end
        end
    end

    // ------------------------------------------------------------
    // Analog settings, capture and interrupt outputs
    // ------------------------------------------------------------
    // Settings go to the core from flops; a cleared on bit puts it in low power.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ana_ctl_q <= '0;
        end else begin
            ana_ctl_q.on      <= on_q;
            ana_ctl_q.hyst_up <= hyp_q;
            ana_ctl_q.hyst_dn <= hyn_q;
            ana_ctl_q.speed   <= spd_q;
        end
    end

    // Timers two and three capture on the clean result.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cap_second_timer_q <= 1'b0;
            cap_third_timer_q  <= 1'b0;
        end else begin
            cap_second_timer_q <= res_q;
            cap_third_timer_q  <= res_q;
        end
    end

    // The divider draws current only while some selector picks it.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            half_div_en_q <= 1'b0;
        end else begin
            half_div_en_q <= (pos_sel == SEL_HALF) || (neg_sel == SEL_HALF);
        end
    end

    // Each flag requests only through its own enable.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= (rise_flag && rie_q) || (fall_flag && fie_q);
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // Writing the on bit reaches the core two edges later.
    property p_on_follows;
        wr_ctl |=> ##1 (ana_ctl_q.on == $past(sfr_req.wdata[CTL_ON], 2));
    endproperty
    a_on_follows: assert property (p_on_follows) else $error("On bit not passed to core.");

    // A disabled comparator never reports a high result.
    property p_off_low;
        !on_q |=> !res_q;
    endproperty
    a_off_low: assert property (p_off_low) else $error("Result high while off.");

    // Reading control returns the result as it stood at the strobe.
    property p_res_read;
        (sfr_req.rd && hit_ctl) |=> (sfr_rdata_q[CTL_RES] == $past(res_q));
    endproperty
    a_res_read: assert property (p_res_read) else $error("Result bit read wrong.");

    // A rising result sets the flag at the next edge.
    property p_rise_set;
        $rose(res_q) |=> rise_flag;
    endproperty
    a_rise_set: assert property (p_rise_set) else $error("Rising flag not set.");

    // A set flag drops only by a control write with a zero in its bit.
    property p_rise_hold;
        (rise_flag && !(wr_ctl && !sfr_req.wdata[CTL_RISE])) |=> rise_flag;
    endproperty
    a_rise_hold: assert property (p_rise_hold) else $error("Rising flag lost.");

    // A falling result sets its flag even under a clearing write.
    property p_fall_set;
        $fell(res_q) |=> fall_flag;
    endproperty
    a_fall_set: assert property (p_fall_set) else $error("Falling flag not set.");

    // A set falling flag drops only by a control write with a zero in its bit.
    property p_fall_hold;
        (fall_flag && !(wr_ctl && !sfr_req.wdata[CTL_FALL])) |=> fall_flag;
    endproperty
    a_fall_hold: assert property (p_fall_hold) else $error("Falling flag lost.");

    // Read data stay put until the next read strobe.
    property p_rdata_hold;
        !sfr_req.rd |=> $stable(sfr_rdata_q);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("Read data changed without a read.");

    // Mode reads show bit 7 high and the unused bits low.
    property p_mode_fixed;
        (sfr_req.rd && hit_mode) |=> ((sfr_rdata_q[7:6] == 2'h2) && (sfr_rdata_q[3:2] == 2'h0));
    endproperty
    a_mode_fixed: assert property (p_mode_fixed) else $error("Fixed mode bits wrong.");

    // The interrupt tracks the gated flags one cycle later.
    property p_irq;
        ##1 (irq_q == $past((rise_flag && rie_q) || (fall_flag && fie_q)));
    endproperty
    a_irq: assert property (p_irq) else $error("Interrupt request wrong.");

    // A mode write reaches the speed output two edges later.
    property p_speed;
        wr_mode |=> ##1 (ana_ctl_q.speed == $past(sfr_req.wdata[MODE_SPD_LO +: 2], 2));
    endproperty
    a_speed: assert property (p_speed) else $error("Speed not passed to core.");

    // Hysteresis codes reach the core two edges after a write.
    property p_hyst;
        wr_ctl |=> ##1 ((ana_ctl_q.hyst_up == $past(sfr_req.wdata[CTL_HYP_LO +: 2], 2))
                        && (ana_ctl_q.hyst_dn == $past(sfr_req.wdata[CTL_HYN_LO +: 2], 2)));
    endproperty
    a_hyst: assert property (p_hyst) else $error("Hysteresis not passed to core.");

    // The divider follows the selectors one cycle later.
    property p_divider;
        ##1 (half_div_en_q == $past((pos_sel == SEL_HALF) || (neg_sel == SEL_HALF)));
    endproperty
    a_divider: assert property (p_divider) else $error("Divider enable wrong.");

    // Capture outputs follow the clean result.
    property p_capture;
        ##1 ((cap_second_timer_q == $past(res_q)) && (cap_third_timer_q == $past(res_q)));
    endproperty
    a_capture: assert property (p_capture) else $error("Capture output wrong.");

    // Scenarios worth seeing.
    c_rise_irq:  cover property (rise_flag && rie_q ##1 irq_q);
    c_set_clear: cover property (rise_evt && wr_ctl && !sfr_req.wdata[CTL_RISE]);
    c_fall_read: cover property (fall_flag && sfr_req.rd && hit_ctl);
    c_fall_irq:  cover property (fall_flag && fie_q ##1 irq_q);

endmodule

/* hdl/cmpreg_pkg.sv */
// Package with the register map, field layout and carriers of the comparator 1 register bank.
package cmpreg_pkg;

    // ------------------------------------------------------------
    // Register bus geometry and addresses
    // ------------------------------------------------------------
    localparam int        ADDR_W       = 8;        // Width of the register address.
    localparam int        PAGE_W       = 4;        // Width of the register page number.
    localparam int        DATA_W       = 8;        // Width of every register.
    localparam logic [7:0] ADDR_CTL    = 8'h9a;    // Control register address.
    localparam logic [7:0] ADDR_MODE   = 8'h9c;    // Mode register address.
    localparam logic [3:0] PAGE_CMP    = 4'h0;     // Page that holds both registers.

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int        CTL_ON       = 7;        // Comparator on bit.
    localparam int        CTL_RES      = 6;        // Live compare result, read only.
    localparam int        CTL_RISE     = 5;        // Sticky rising-edge flag.
    localparam int        CTL_FALL     = 4;        // Sticky falling-edge flag.
    localparam int        CTL_HYP_LO   = 2;        // Low bit of the upper hysteresis field.
    localparam int        CTL_HYN_LO   = 0;        // Low bit of the lower hysteresis field.
    localparam logic [7:0] CTL_RESET   = 8'h00;    // Reset value of the control register.

    // ------------------------------------------------------------
    // Mode register fields
    // ------------------------------------------------------------
    localparam int        MODE_RSV     = 7;        // Reserved bit, always reads one.
    localparam int        MODE_RIE     = 5;        // Rising-edge interrupt enable.
    localparam int        MODE_FIE     = 4;        // Falling-edge interrupt enable.
    localparam int        MODE_SPD_LO  = 0;        // Low bit of the response speed field.
    localparam logic [7:0] MODE_RESET  = 8'h82;    // Reset value of the mode register.
    localparam logic [1:0] SPD_RESET   = 2'h2;     // Reset value of the speed field.

    // ------------------------------------------------------------
    // Analog settings
    // ------------------------------------------------------------
    localparam logic [3:0] SEL_HALF    = 4'hd;     // Input selector code of the half-supply divider.
    localparam logic [1:0] HYST_OFF    = 2'h0;     // Hysteresis disabled.
    localparam int        HYST_MV_1    = 5;        // Nominal millivolts of hysteresis level one.
    localparam int        HYST_MV_2    = 10;       // Nominal millivolts of hysteresis level two.
    localparam int        HYST_MV_3    = 20;       // Nominal millivolts of hysteresis level three.

    // Request from the core's register bus.
    typedef struct packed {
        logic                wr;                   // Write strobe, one cycle.
        logic                rd;                   // Read strobe, one cycle.
        logic [PAGE_W-1:0]   page;                 // Current register page.
        logic [ADDR_W-1:0]   addr;                 // Register address.
        logic [DATA_W-1:0]   wdata;                // Write data.
    } cmpreg_sfr_req_t;

    // Settings driven into the analog comparator core.
    typedef struct packed {
        logic       on;                            // Powered and running when one.
        logic [1:0] hyst_up;                       // Upper hysteresis level code.
        logic [1:0] hyst_dn;                       // Lower hysteresis level code.
        logic [1:0] speed;                         // Response speed code, 00 fastest.
    } cmpreg_ana_ctl_t;

    // Nominal hysteresis in millivolts for a level code.
    function automatic int cmpreg_hyst_mv(input logic [1:0] code);
        unique case (code)
            2'h0: cmpreg_hyst_mv = 0;
            2'h1: cmpreg_hyst_mv = HYST_MV_1;
            2'h2: cmpreg_hyst_mv = HYST_MV_2;
            2'h3: cmpreg_hyst_mv = HYST_MV_3;
        endcase
    endfunction

endpackage

/* hdl/cmpreg_sync.sv */
// Level synchroniser for the asynchronous comparator output.
`timescale 1ns/1ps
module cmpreg_sync #(
    parameter int STAGES = 2                      // Number of flip-flops in the chain.
) (
    // Clock and reset.
    input  wire logic ref_clk,
    input  wire logic rst_n,
    // Level in and out.
    input  wire logic async_in,
    output logic      sync_out
);

    // ------------------------------------------------------------
    // Chain
    // ------------------------------------------------------------
    logic [STAGES-1:0] chain_q;                   // Only the last stage is read outside.

    // Refuse a chain too short to settle metastability.
    if (STAGES < 2) begin : g_chk
        $error("cmpreg_sync needs at least two stages.");
    end

    // Shift the input through the chain.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            chain_q <= '0;
        end else begin
            chain_q <= {chain_q[STAGES-2:0], async_in};
        end
    end

    assign sync_out = chain_q[STAGES-1];

endmodule

/* hdl/cmpreg_flag.sv */
// Sticky event flag that hardware sets and software writes.
`timescale 1ns/1ps
module cmpreg_flag (
    // Clock and reset.
    input  wire logic ref_clk,
    input  wire logic rst_n,
    // Event and software write.
    input  wire logic set_evt,
    input  wire logic wr_en,
    input  wire logic wr_bit,
    // Flag state.
    output logic      flag_q
);

    // ------------------------------------------------------------
    // Flag
    // ------------------------------------------------------------
    logic flag_d;                                 // Next flag value.

    // A set in the same cycle as a software clear wins.
    always_comb begin
        flag_d = set_evt | (wr_en ? wr_bit : flag_q);
    end

    // Only software or reset ever takes the flag back to zero.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end

endmodule

/* testbench/cmpreg_top_tb.sv */
// Self-checking testbench of the comparator 1 register bank.
`timescale 1ns/1ps
module cmpreg_top_tb;
    import cmpreg_pkg::*;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic                    ref_clk = 1'b0;      // Bench clock, 40 ns period.
    logic                    rst_n;               // Asynchronous reset, active low.
    cmpreg_sfr_req_t         sfr_req;             // Register bus request.
    logic [DATA_W-1:0]       sfr_rdata_q;         // Register read data.
    logic                    cmp_raw;             // Raw comparator output.
    logic [3:0]              pos_sel;             // Positive input selector.
    logic [3:0]              neg_sel;             // Negative input selector.
    cmpreg_ana_ctl_t         ana_ctl_q;           // Analog settings.
    logic                    half_div_en_q;       // Divider enable.
    logic                    cap_second_timer_q;  // Capture input of the second timer.
    logic                    cap_third_timer_q;   // Capture input of the third timer.
    logic                    irq_q;               // Interrupt request.
    int                      n_fail = 0;          // Mismatches seen.
    int                      checks = 0;          // Comparisons made.

    // The clock toggles every half period.
    always #20 ref_clk = ~ref_clk;

    // ------------------------------------------------------------
    // Design under test
    // ------------------------------------------------------------
    cmpreg_top #(.SYNC_STAGES(2)) u_cmpreg_top (
        .ref_clk            (ref_clk),
        .rst_n              (rst_n),
        .sfr_req            (sfr_req),
        .sfr_rdata_q        (sfr_rdata_q),
        .cmp_raw            (cmp_raw),
        .pos_sel            (pos_sel),
        .neg_sel            (neg_sel),
        .ana_ctl_q          (ana_ctl_q),
        .half_div_en_q      (half_div_en_q),
        .cap_second_timer_q (cap_second_timer_q),
        .cap_third_timer_q  (cap_third_timer_q),
        .irq_q              (irq_q)
    );

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    // Waits for n rising edges and lets their updates settle.
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // Compares a seen value with the expected one and counts every comparison and every mismatch.
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Writes one byte; the strobe stands for exactly one edge.
    task automatic reg_wr(input logic [3:0] pg, input logic [7:0] a, input logic [7:0] d);
        sfr_req.page  = pg;
        sfr_req.addr  = a;
        sfr_req.wdata = d;
        sfr_req.wr    = 1'b1;
        tick(1);
        sfr_req.wr    = 1'b0;
    endtask

    // Reads one byte and compares it; the data stands until the next read.
    task automatic reg_rd(input logic [3:0] pg, input logic [7:0] a, input logic [7:0] exp);
        sfr_req.page = pg;
        sfr_req.addr = a;
        sfr_req.rd   = 1'b1;
        tick(1);
        sfr_req.rd   = 1'b0;
        tick(1);
        chk(sfr_rdata_q, exp);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic print_verdict();
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Watchdog, far beyond the hundred or so cycles the tests need
    // ------------------------------------------------------------
    initial begin
        #(40 * 5000);
        n_fail++;
        print_verdict();
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        sfr_req = '0;
        cmp_raw = 1'b0;
        pos_sel = 4'h0;
        neg_sel = 4'h0;
        repeat (5) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        tick(2);
        chk({1'b0, ana_ctl_q}, 8'h02);
        reg_rd(PAGE_CMP, ADDR_CTL, 8'h00);
        reg_rd(PAGE_CMP, ADDR_MODE, 8'h82);
        reg_wr(PAGE_CMP, ADDR_MODE, 8'hff);
        reg_rd(PAGE_CMP, ADDR_MODE, 8'hb3);
        reg_wr(PAGE_CMP, ADDR_MODE, 8'hcc);
        reg_rd(PAGE_CMP, ADDR_MODE, 8'h80);
        // Every speed code reaches the comparator core.
        for (int i = 0; i < 4; i++) begin
            reg_wr(PAGE_CMP, ADDR_MODE, {6'h20, i[1:0]});
            tick(2);
            chk({6'h0, ana_ctl_q.speed}, {6'h0, i[1:0]});
        end
        // Every hysteresis code on both sides, opposite codes at once.
        for (int i = 0; i < 4; i++) begin
            reg_wr(PAGE_CMP, ADDR_CTL, {4'h8, i[1:0], ~i[1:0]});
            tick(2);
            chk({1'b0, ana_ctl_q}, {2'b01, i[1:0], ~i[1:0], 2'h3});
        end
        // Other pages and addresses neither decode nor disturb.
        reg_wr(4'h1, ADDR_CTL, 8'h00);
        reg_rd(PAGE_CMP, ADDR_CTL, 8'h8c);
        reg_rd(PAGE_CMP, 8'h9b, 8'h00);
        reg_rd(4'h1, ADDR_CTL, 8'h00);
        // Rising then falling edge; both flags stick, no enables yet.
        reg_wr(PAGE_CMP, ADDR_CTL, 8'h80);
        tick(1);
        reg_wr(PAGE_CMP, ADDR_MODE, 8'h80);
        cmp_raw = 1'b1;
        tick(8);
        reg_rd(PAGE_CMP, ADDR_CTL, 8'he0);
        chk({6'h0, cap_second_timer_q, cap_third_timer_q}, 8'h03);
        chk({7'h0, irq_q}, 8'h00);
        cmp_raw = 1'b0;
        tick(8);
        reg_rd(PAGE_CMP, ADDR_CTL, 8'hb0);
        chk({6'h0, cap_second_timer_q, cap_third_timer_q}, 8'h00);
        // Each enable gates only its own flag.
        reg_wr(PAGE_CMP, ADDR_MODE, 8'ha0);
        tick(3);
        chk({7'h0, irq_q}, 8'h01);
        reg_wr(PAGE_CMP, ADDR_CTL, 8'h90);
        tick(3);
        chk({7'h0, irq_q}, 8'h00);
        reg_wr(PAGE_CMP, ADDR_MODE, 8'h90);
        tick(3);
        chk({7'h0, irq_q}, 8'h01);
        reg_wr(PAGE_CMP, ADDR_CTL, 8'h80);
        tick(3);
        chk({7'h0, irq_q}, 8'h00);
        reg_rd(PAGE_CMP, ADDR_CTL, 8'h80);
        // A switched-off comparator shows no result.
        cmp_raw = 1'b1;
        reg_wr(PAGE_CMP, ADDR_CTL, 8'h00);
        tick(8);
        reg_rd(PAGE_CMP, ADDR_CTL, 8'h00);
        // Switching on with the input high latches a false rise; a clear
        // landing in the same cycle as that rise still leaves the flag set.
        reg_wr(PAGE_CMP, ADDR_CTL, 8'h80);
        tick(1);
        reg_wr(PAGE_CMP, ADDR_CTL, 8'h80);
        reg_rd(PAGE_CMP, ADDR_CTL, 8'he0);
        reg_wr(PAGE_CMP, ADDR_CTL, 8'h80);
        reg_rd(PAGE_CMP, ADDR_CTL, 8'hc0);
        // Divider powers up only while one selector picks it.
        for (int i = 0; i < 3; i++) begin
            pos_sel = (i == 0) ? SEL_HALF : 4'h0;
            neg_sel = (i == 1) ? SEL_HALF : 4'h0;
            tick(3);
            chk({7'h0, half_div_en_q}, (i < 2) ? 8'h01 : 8'h00);
        end
        print_verdict();
    end
endmodule
